//--- sim/aip_audio_input_port_tb.sv
// self-checking bench for the multichannel audio input port
`timescale 1ns/1ps
`default_nettype none
module aip_audio_input_port_tb;
  import aip_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [PIN_N-1:0]  pin_in;
  logic [CH_N-1:0]   chan_en, chan_overrun, ovr_seen;
  aip_fmt_t          chan_fmt [CH_N];
  logic [2:0]        chan_width [CH_N];
  logic [SEL_W-1:0]  chan_bclk_sel [CH_N], chan_fs_sel [CH_N], chan_dat_sel [CH_N];
  logic [WORD_W-1:0] fifo_data, q0 [$], q1 [$];
  logic              fifo_valid, fifo_ready = 1'b0, halt = 1'b0;
  logic              lossy_run = 1'b0, hit;
  logic [LVL_W-1:0]  fifo_level;
  logic [PIN_N-1:0]  noise = '0;
  logic              b0, f0, d0, b1, f1, d1;
  int                bad_count = 0, compares = 0, seed = 48747, popped, max_lvl;
  aip_fmt_t          fmt_tab [8] = '{FMT_I2S, FMT_I2S, FMT_LJ, FMT_LJ,
                                     FMT_RJ, FMT_RJ, FMT_RJ, FMT_RJ};
  logic [2:0]        wid_tab [8] = '{WID_24, WID_32, WID_24, WID_32,
                                     WID_16, WID_18, WID_20, WID_24};

  // channel 0 on pins 0..2, channel 5 on pins 10..12, noise elsewhere
  assign pin_in = {noise[19:13], d1, f1, b1, noise[9:3], d0, f0, b0};

  aip_src u_s0 (.bclk(b0), .fs(f0), .dat(d0));
  aip_src u_s1 (.bclk(b1), .fs(f1), .dat(d1));

  aip_audio_input_port u_dut (
    .ref_clk(ref_clk), .rst(rst), .pin_in(pin_in), .chan_en(chan_en),
    .chan_fmt(chan_fmt), .chan_width(chan_width), .chan_bclk_sel(chan_bclk_sel),
    .chan_fs_sel(chan_fs_sel), .chan_dat_sel(chan_dat_sel), .fifo_data(fifo_data),
    .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_level(fifo_level),
    .chan_overrun(chan_overrun));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  function automatic logic [31:0] exp_word(aip_fmt_t f, logic [2:0] w, logic [31:0] h);
    if (f != FMT_RJ)
      return (w == WID_24) ? {h[31:8], 8'h00} : h;
    case (w)
      WID_16:  return {h[15:0], 16'h0000};
      WID_18:  return {h[17:0], 14'h0000};
      WID_20:  return {h[19:0], 12'h000};
      default: return {h[23:0], 8'h00};
    endcase
  endfunction

  // random stalls on the reader; words are taken where valid and ready settle
  always @(posedge ref_clk) begin
    #1 fifo_ready = ~halt & ($random(seed) % 4 != 0);
    noise = PIN_N'($random(seed));
  end
  always @(negedge ref_clk) begin
    if (!rst) begin
      max_lvl = (fifo_level > max_lvl) ? fifo_level : max_lvl;
      ovr_seen |= chan_overrun;
      if (fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
        popped++;
        hit = 1'b0;
        if (q0.size() > 0 && q0[0] === fifo_data) begin
          void'(q0.pop_front());
          hit = 1'b1;
        end else if (q1.size() > 0 && q1[0] === fifo_data) begin
          void'(q1.pop_front());
          hit = 1'b1;
        end else if (lossy_run) begin
          // dropped words leave gaps, but what arrives keeps its channel order
          for (int i = 0; i < q0.size() && !hit; i++) begin
            if (q0[i] === fifo_data) begin
              hit = 1'b1;
              repeat (i + 1) void'(q0.pop_front());
            end
          end
          for (int i = 0; i < q1.size() && !hit; i++) begin
            if (q1[i] === fifo_data) begin
              hit = 1'b1;
              repeat (i + 1) void'(q1.pop_front());
            end
          end
        end
        check(hit, "unexpected fifo word");
      end
    end
  end

  // nf frames on one source; expectations queued only while enabled
  task automatic feed(input int c, input int t, input logic on, input int nf);
    logic [63:0] lr;
    for (int f = 0; f < nf; f++) begin
      lr = {$random(seed), $random(seed)};
      if (on && c == 0)
        q0 = {q0, exp_word(fmt_tab[t], wid_tab[t], lr[63:32]),
              exp_word(fmt_tab[t], wid_tab[t], lr[31:0])};
      if (on && c == 1)
        q1 = {q1, exp_word(fmt_tab[t], wid_tab[t], lr[63:32]),
              exp_word(fmt_tab[t], wid_tab[t], lr[31:0])};
      if (c == 0) u_s0.send(fmt_tab[t] == FMT_I2S, lr, 64);
      else u_s1.send(fmt_tab[t] == FMT_I2S, lr, 64);
    end
    if (c == 0) u_s0.send(fmt_tab[t] == FMT_I2S, 64'h0, 1);
    else u_s1.send(fmt_tab[t] == FMT_I2S, 64'h0, 1);
    #800;
  endtask

  task automatic run(input int a, input int b, input logic [1:0] en, input int nf,
                     input logic lossy);
    int t;
    @(posedge ref_clk);
    #1 chan_en = '0;
    chan_fmt[0] = fmt_tab[a];
    chan_width[0] = wid_tab[a];
    chan_fmt[5] = fmt_tab[b];
    chan_width[5] = wid_tab[b];
    u_s0.prime(fmt_tab[a] == FMT_I2S);
    u_s1.prime(fmt_tab[b] == FMT_I2S);
    repeat (4) @(posedge ref_clk);
    #1 chan_en[0] = en[0];
    chan_en[5] = en[1];
    halt = lossy;
    lossy_run = lossy;
    popped = 0;
    max_lvl = 0;
    ovr_seen = '0;
    fork
      feed(0, a, en[0], nf);
      feed(1, b, en[1], nf);
    join
    if (lossy) begin
      check(max_lvl == FIFO_DEPTH, "fifo never filled");
      check(ovr_seen[0] === 1'b1 && ovr_seen[5] === 1'b1, "no overrun");
      #1 halt = 1'b0;
    end
    // after an overrun the queues keep the dropped words, so only the fifo is waited on
    for (t = 0; t < 3000 && ((!lossy && (q0.size() > 0 || q1.size() > 0))
                             || fifo_level !== 0); t++)
      @(posedge ref_clk);
    if (t == 3000) begin
      check(1'b0, "drain timed out");
      tally_and_finish();
    end
    if (lossy) begin
      check(popped >= FIFO_DEPTH, "too few words after overrun");
      q0.delete();
      q1.delete();
    end else begin
      check(popped == 2 * nf * (en[0] + en[1]), "word count");
    end
  endtask

  initial begin
    chan_en = '0;
    for (int c = 0; c < CH_N; c++) begin
      chan_fmt[c] = FMT_I2S;
      chan_width[c] = WID_32;
      chan_bclk_sel[c] = 5'h1f;
      chan_fs_sel[c] = 5'h1f;
      chan_dat_sel[c] = 5'h1f;
    end
    {chan_bclk_sel[0], chan_fs_sel[0], chan_dat_sel[0]} = {5'h00, 5'h01, 5'h02};
    {chan_bclk_sel[5], chan_fs_sel[5], chan_dat_sel[5]} = {5'h0a, 5'h0b, 5'h0c};
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    @(negedge ref_clk);
    check(fifo_valid === 1'b0 && fifo_level === '0, "fifo not empty after reset");
    for (int i = 0; i < 8; i++)
      run(i, (i + 3) % 8, 2'b11, 2, 1'b0);
    run(1, 4, 2'b01, 2, 1'b0);
    run(2, 6, 2'b11, 5, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- sim/aip_src.sv
// behavioural serial audio source for one channel: bit clock, frame sync, data
`timescale 1ns/1ps
`default_nettype none
module aip_src (
  output logic bclk, // bit clock, still between frames
  output logic fs,   // frame sync
  output logic dat   // serial data
);
  logic lsb; // right word lsb, sent on the next sync change in i2s
  initial begin
    bclk = 1'b0;
    fs   = 1'b0;
    dat  = 1'b0;
    lsb  = 1'b0;
  end
  // one bit clock edge at the right-half level, so the first edge of a frame is a change
  task automatic prime(input logic i2s);
    fs = i2s;
    #200 bclk = 1'b1;
    #200 bclk = 1'b0;
  endtask
  // n edges of a 64-bit frame {left, right}; n = 1 gives the closing sync edge
  task automatic send(input logic i2s, input logic [63:0] lr, input int n);
    int j;
    for (int k = 0; k < n; k++) begin
      j = i2s ? k - 1 : k;
      fs = (k < 32) ^ i2s;
      dat = (j < 0) ? lsb : lr[63 - j];
      #200 bclk = 1'b1;
      #200 bclk = 1'b0;
    end
    lsb = lr[0];
    dat = ~dat; // no hold past the frame
  endtask
endmodule
`default_nettype wire

//--- verilog/aip_audio_input_port.sv
// multichannel serial audio input port: pin routing, deserialisers, merge into FIFO
`timescale 1ns/1ps
`default_nettype none
module aip_audio_input_port (
  input  wire logic                      ref_clk,                 // 20 MHz system clock
  input  wire logic                      rst,                     // sync reset, high
  input  wire logic [aip_pkg::PIN_N-1:0] pin_in,                  // audio pin interface pins
  input  wire logic [aip_pkg::CH_N-1:0]  chan_en,                 // channel enable
  input  wire aip_pkg::aip_fmt_t         chan_fmt [aip_pkg::CH_N], // framing per channel
  input  wire logic [2:0]                chan_width [aip_pkg::CH_N], // width code
  input  wire logic [aip_pkg::SEL_W-1:0] chan_bclk_sel [aip_pkg::CH_N], // bit clock pin
  input  wire logic [aip_pkg::SEL_W-1:0] chan_fs_sel [aip_pkg::CH_N],   // frame sync pin
  input  wire logic [aip_pkg::SEL_W-1:0] chan_dat_sel [aip_pkg::CH_N],  // data pin
  output logic [aip_pkg::WORD_W-1:0]     fifo_data,               // oldest word
  output logic                           fifo_valid,              // word available
  input  wire logic                      fifo_ready,              // reader takes word
  output logic [aip_pkg::LVL_W-1:0]      fifo_level,              // words held
  output logic [aip_pkg::CH_N-1:0]       chan_overrun             // word dropped, pulse
);
  import aip_pkg::*;

  function automatic logic route_pick(input logic [PIN_N-1:0] pins,
                                      input logic [SEL_W-1:0] sel);
    route_pick = (sel < SEL_W'(PIN_N)) ? pins[sel] : 1'b0;
  endfunction

  function automatic logic [5:0] sample_bits(input aip_fmt_t fmt, input logic [2:0] wc);
    sample_bits = BITS_24;
    if (fmt == FMT_RJ) begin
      case (wc)
        WID_16:  sample_bits = BITS_16;
        WID_18:  sample_bits = BITS_18;
        WID_20:  sample_bits = BITS_20;
        default: sample_bits = BITS_24;
      endcase
    end else if (wc == WID_32) begin
      sample_bits = WORD_BITS;
    end
  endfunction

  // samples leave the port msb-aligned with unused low bits zero
  function automatic logic [WORD_W-1:0] align_word(input aip_fmt_t fmt, input logic [2:0] wc,
                                                   input logic [WORD_W-1:0] raw);
    logic [5:0] nb;
    nb = sample_bits(fmt, wc);
    if (fmt == FMT_RJ) begin
      align_word = raw << (WORD_BITS - nb);
    end else begin
      align_word = raw & ~({WORD_W{1'b1}} >> nb);
    end
  endfunction

  logic [PIN_N-1:0]  pin_meta;
  logic [PIN_N-1:0]  pin_sync;
  logic              r_bclk [CH_N];
  logic              r_fs [CH_N];
  logic              r_dat [CH_N];
  logic              bclk_last [CH_N];
  logic              fs_last [CH_N];
  logic [WORD_W-1:0] shreg [CH_N];
  logic              started [CH_N];
  logic              left_ok [CH_N];
  logic [WORD_W-1:0] hold [CH_N];
  logic [CH_N-1:0]   hold_v;
  logic [CH_N-1:0]   bedge;
  logic [CH_N-1:0]   fs_chg;
  logic [CH_N-1:0]   ended_left;
  logic [CH_N-1:0]   wanted;
  logic [CH_N-1:0]   fill;
  logic [CH_N-1:0]   drain;
  logic [WORD_W-1:0] fill_word [CH_N];
  logic [CH_W-1:0]   rr_ptr;
  logic              push_ready;

  // pins are asynchronous to ref_clk; routing reads only the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      r_bclk[c] = route_pick(pin_sync, chan_bclk_sel[c]);
      r_fs[c]   = route_pick(pin_sync, chan_fs_sel[c]);
      r_dat[c]  = route_pick(pin_sync, chan_dat_sel[c]);
    end
  end

  // a half-frame closes on the bit clock edge where frame sync changes level
  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      bedge[c]      = r_bclk[c] & ~bclk_last[c];
      fs_chg[c]     = r_fs[c] != fs_last[c];
      // i2s marks left with sync low, the justified modes with sync high
      ended_left[c] = (chan_fmt[c] == FMT_I2S) ? ~fs_last[c] : fs_last[c];
      // i2s is delayed by one bit, so the sync-change bit is still the old lsb
      fill_word[c]  = align_word(chan_fmt[c], chan_width[c],
                                 (chan_fmt[c] == FMT_I2S) ? {shreg[c][WORD_W-2:0], r_dat[c]}
                                                          : shreg[c]);
      wanted[c]     = bedge[c] & fs_chg[c] & started[c] & chan_en[c]
                      & (ended_left[c] | left_ok[c]);
      drain[c]      = (rr_ptr == CH_W'(c)) & hold_v[c] & push_ready;
      fill[c]       = wanted[c] & (~hold_v[c] | drain[c]);
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < CH_N; c++) begin
      if (rst) begin
        bclk_last[c] <= 1'b0;
        fs_last[c]   <= 1'b0;
        shreg[c]     <= '0;
        started[c]   <= 1'b0;
      end else begin
        bclk_last[c] <= r_bclk[c];
        if (bedge[c]) begin
          fs_last[c] <= r_fs[c];
          if (fs_chg[c] && chan_fmt[c] == FMT_I2S) begin
            shreg[c] <= '0;
          end else if (fs_chg[c]) begin
            shreg[c] <= {{(WORD_W-1){1'b0}}, r_dat[c]};
          end else begin
            shreg[c] <= {shreg[c][WORD_W-2:0], r_dat[c]};
          end
        end
        // the partial half seen at enable is thrown away
        if (!chan_en[c]) begin
          started[c] <= 1'b0;
        end else if (bedge[c] && fs_chg[c]) begin
          started[c] <= 1'b1;
        end
      end
    end
  end

  // a dropped left word forces its right partner to be dropped too
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < CH_N; c++) begin
      if (rst || !chan_en[c]) begin
        left_ok[c] <= 1'b0;
      end else if (wanted[c]) begin
        left_ok[c] <= fill[c] & ended_left[c];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < CH_N; c++) begin
      if (rst) begin
        hold[c]   <= '0;
        hold_v[c] <= 1'b0;
      end else if (fill[c]) begin
        hold[c]   <= fill_word[c];
        hold_v[c] <= 1'b1;
      end else if (drain[c]) begin
        hold_v[c] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chan_overrun <= '0;
    end else begin
      chan_overrun <= wanted & ~fill;
    end
  end

  // one channel looked at per cycle; a full loop is far shorter than a half-frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rr_ptr <= RR_RESET;
    end else begin
      rr_ptr <= rr_ptr + RR_STEP;
    end
  end

  aip_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (hold[rr_ptr]),
    .in_valid  (hold_v[rr_ptr]),
    .in_ready  (push_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .level     (fifo_level)
  );

  property p_route;
    @(posedge ref_clk) disable iff (rst)
      ($past(chan_bclk_sel[0], 1) == chan_bclk_sel[0] && $past(chan_bclk_sel[0], 2) == chan_bclk_sel[0]
       && !$past(rst, 2)) |-> r_bclk[0] == $past(route_pick(pin_in, chan_bclk_sel[0]), 2);
  endproperty
  a_route: assert property (p_route) else $error("routed clock not from selected pin");

  property p_fill_on_sync;
    @(posedge ref_clk) disable iff (rst) fill[0] |-> bedge[0] && fs_chg[0] && chan_en[0];
  endproperty
  a_fill_on_sync: assert property (p_fill_on_sync) else $error("word outside half-frame end");

  property p_disabled_quiet;
    @(posedge ref_clk) disable iff (rst) !chan_en[5] |=> !hold_v[5] || $past(hold_v[5]);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled channel filled");

  property p_right_after_left;
    @(posedge ref_clk) disable iff (rst) (fill[0] && !ended_left[0]) |-> left_ok[0];
  endproperty
  a_right_after_left: assert property (p_right_after_left) else $error("right word without left");

  property p_left_arms;
    @(posedge ref_clk) disable iff (rst)
      (fill[0] && ended_left[0] && chan_en[0]) |=> left_ok[0] && hold_v[0];
  endproperty
  a_left_arms: assert property (p_left_arms) else $error("left word did not arm right");

  property p_rj16;
    @(posedge ref_clk) disable iff (rst)
      (fill[0] && chan_fmt[0] == FMT_RJ && chan_width[0] == WID_16) |=> hold[0][15:0] == 16'h0000;
  endproperty
  a_rj16: assert property (p_rj16) else $error("rj16 word has low bits set");

  property p_i2s24;
    @(posedge ref_clk) disable iff (rst)
      (fill[0] && chan_fmt[0] == FMT_I2S && chan_width[0] == WID_24)
      |=> hold[0][7:0] == 8'h00 && hold[0][31:8] == $past(fill_word[0][31:8]);
  endproperty
  a_i2s24: assert property (p_i2s24) else $error("i2s24 word misaligned");

  property p_lj_restart;
    @(posedge ref_clk) disable iff (rst)
      (bedge[0] && fs_chg[0] && chan_fmt[0] == FMT_LJ)
      |=> shreg[0] == {31'h0000_0000, $past(r_dat[0])};
  endproperty
  a_lj_restart: assert property (p_lj_restart) else $error("lj half did not restart");

  property p_drain;
    @(posedge ref_clk) disable iff (rst)
      (hold_v[0] && !fill[0] && push_ready) |-> ##[0:8] !hold_v[0] || fill[0] || !push_ready;
  endproperty
  a_drain: assert property (p_drain) else $error("held word not merged");

  c_left: cover property (@(posedge ref_clk) disable iff (rst) fill[0] && ended_left[0]);
  c_pair: cover property (@(posedge ref_clk) disable iff (rst) fill[0] && !ended_left[0]);
  c_over: cover property (@(posedge ref_clk) disable iff (rst) chan_overrun != '0);
  c_pop:  cover property (@(posedge ref_clk) disable iff (rst) fifo_valid && fifo_ready);
endmodule
`default_nettype wire

//--- verilog/aip_fifo.sv
// shared word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module aip_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic                       ref_clk,   // system clock
  input  wire logic                       rst,       // sync reset, high
  input  wire logic [WIDTH-1:0]           in_data,   // word to store
  input  wire logic                       in_valid,  // word offered
  output logic                            in_ready,  // room for a word
  output logic [WIDTH-1:0]                out_data,  // oldest word
  output logic                            out_valid, // a word is held
  input  wire logic                       out_ready, // reader takes word
  output logic [$clog2(DEPTH+1)-1:0]      level      // words held
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [$clog2(DEPTH+1)-1:0] FULL = ($clog2(DEPTH+1))'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic             push;
  logic             pop;

  assign in_ready  = level != FULL;
  assign out_valid = level != '0;
  assign out_data  = mem[rd_idx];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + AW'(1);
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + AW'(1);
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end

  property p_fifo_bound;
    @(posedge ref_clk) disable iff (rst) level <= FULL;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo level above depth");

  property p_fifo_full_stall;
    @(posedge ref_clk) disable iff (rst) (level == FULL && !pop) |=> level == FULL && !in_ready;
  endproperty
  a_fifo_full_stall: assert property (p_fifo_full_stall) else $error("full fifo took a word");

  c_fifo_full: cover property (@(posedge ref_clk) disable iff (rst) level == FULL);
endmodule
`default_nettype wire

//--- verilog/aip_pkg.sv
// constants and types shared by the multichannel audio input port
`default_nettype none
package aip_pkg;
  localparam int CH_N       = 8;
  localparam int CH_W       = 3;
  localparam int PIN_N      = 20;
  localparam int SEL_W      = 5;
  localparam int WORD_W     = 32;
  localparam int FRAME_BITS = 64;
  localparam int FIFO_DEPTH = 8;
  localparam int LVL_W      = 4;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [CH_W-1:0] RR_RESET = 3'h0;
  localparam logic [CH_W-1:0] RR_STEP  = 3'h1;

  typedef enum logic [1:0] {FMT_I2S, FMT_LJ, FMT_RJ} aip_fmt_t;

  // sample width codes
  localparam logic [2:0] WID_16 = 3'h0;
  localparam logic [2:0] WID_18 = 3'h1;
  localparam logic [2:0] WID_20 = 3'h2;
  localparam logic [2:0] WID_24 = 3'h3;
  localparam logic [2:0] WID_32 = 3'h4;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_18 = 6'h12;
  localparam logic [5:0] BITS_20 = 6'h14;
  localparam logic [5:0] BITS_24 = 6'h18;
endpackage
`default_nettype wire
